// ===== tiop_pkg.sv
// package of constants and types for the timed i/o port unit
package tiop_pkg;

    // =========================================================
    // sizes
    localparam int NUM_PORTS = 5;
    localparam int NUM_CB = 6;
    localparam int PIN_W = 32;
    localparam int CNT_W = 16;
    localparam int DIV_W = 8;
    localparam int ADDR_W = 8;

    // =========================================================
    // clocking: the reference clock block ticks on every rising clk edge
    localparam int REF_CLK_DEFAULT_MHZ = 100;
    localparam int CLK_MHZ = 20;
    localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;

    // =========================================================
    // register map: addr[7:4] selects a page, addr[3:0] a register
    localparam logic [3:0] PAGE_CB = 4'h5;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h1;
    localparam logic [3:0] REG_TIME = 4'h2;
    localparam logic [3:0] REG_COND = 4'h3;
    localparam logic [3:0] REG_CNT = 4'h4;
    localparam logic [3:0] REG_TSTAMP = 4'h5;
    localparam logic [3:0] REG_STAT = 4'h6;

    // pins handed to the inter-chip link when it is enabled
    localparam logic [PIN_W-1:0] LINK_PIN_MASK = 32'hFF00_0000;

    // =========================================================
    // sampling condition modes
    typedef enum logic [1:0] {
        COND_NONE = 2'b00,
        COND_EQ = 2'b01,
        COND_NE = 2'b10
    } tiop_cond_type;

    // port configuration, enable in bit 0
    typedef struct packed {
        logic [2:0] cb_sel;
        logic timed;
        tiop_cond_type cond_mode;
        logic strobe_en;
        logic open_col;
        logic dir_out;
        logic enable;
    } tiop_cfg_type;
    localparam int CFG_W = $bits(tiop_cfg_type);
    localparam tiop_cfg_type CFG_RST = '0;

    // port data path state
    typedef struct packed {
        logic [PIN_W-1:0] xfer;
        logic [PIN_W-1:0] pval;
        logic [PIN_W-1:0] cond;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] ptime;
        logic [CNT_W-1:0] tstamp;
        logic valid;
    } tiop_state_type;
    localparam tiop_state_type STATE_RST = '0;

    // clock block configuration; div of zero passes the source through
    typedef struct packed {
        logic from_pin;
        logic [DIV_W-1:0] div;
    } tiop_cb_type;
    localparam int CB_W = $bits(tiop_cb_type);
    localparam tiop_cb_type CB_RST = '0;

    // nominal width of each port, narrowest first
    function automatic int port_width(input int idx);
        case (idx)
            0: port_width = 1;
            1: port_width = 4;
            2: port_width = 8;
            3: port_width = 16;
            default: port_width = 32;
        endcase
    endfunction : port_width

    // mask of the data bits a port carries
    function automatic logic [PIN_W-1:0] port_mask(input int idx);
        port_mask = (port_width(idx) >= PIN_W) ? '1 : PIN_W'((64'h1 << port_width(idx)) - 64'h1);
    endfunction : port_mask

endpackage : tiop_pkg

// ===== tiop_port_unit.sv
// timed i/o port unit: five ports, six clock blocks, pin multiplexer
`timescale 1ns/10ps

module tiop_port_unit (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [tiop_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_we,
    input wire logic bus_re,
    output logic [31:0] bus_rdata,
    input wire logic link_en,
    input wire logic [tiop_pkg::PIN_W-1:0] pin_in,
    output logic [tiop_pkg::PIN_W-1:0] pin_out,
    output logic [tiop_pkg::PIN_W-1:0] pin_oe,
    output logic [tiop_pkg::PIN_W-1:0] pin_pd,
    input wire logic [tiop_pkg::NUM_PORTS-1:0] strobe_in_qualifier,
    output logic [tiop_pkg::NUM_PORTS-1:0] strobe_out_qualifier
);
    import tiop_pkg::*;

    // =========================================================
    // state
    tiop_cfg_type cfg_r [NUM_PORTS];
    tiop_cfg_type cfg_nxt [NUM_PORTS];
    tiop_state_type st_r [NUM_PORTS];
    tiop_state_type st_nxt [NUM_PORTS];
    tiop_cb_type cb_r [NUM_CB];
    tiop_cb_type cb_nxt [NUM_CB];
    logic [DIV_W-1:0] cbcnt_r [NUM_CB];
    logic [DIV_W-1:0] cbcnt_nxt [NUM_CB];
    logic pin0_prev_r;
    logic pin0_prev_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [PIN_W-1:0] pin_out_r;
    logic [PIN_W-1:0] pin_out_nxt;
    logic [PIN_W-1:0] pin_oe_r;
    logic [PIN_W-1:0] pin_oe_nxt;
    logic [PIN_W-1:0] pin_pd_r;
    logic [NUM_PORTS-1:0] strobe_r;
    logic [NUM_PORTS-1:0] strobe_nxt;

    // combinational helpers
    logic [NUM_CB-1:0] cb_tick;
    logic [NUM_PORTS-1:0] port_tick;
    logic [NUM_PORTS-1:0] xfer_evt;
    logic [3:0] page;
    logic [3:0] regsel;

    assign page = bus_addr[7:4];
    assign regsel = bus_addr[3:0];

    // outputs straight from flops
    assign bus_rdata = rdata_r;
    assign pin_out = pin_out_r;
    assign pin_oe = pin_oe_r;
    assign pin_pd = pin_pd_r;
    assign strobe_out_qualifier = strobe_r;

    // =========================================================
    // clock blocks
    always_comb
    begin
        pin0_prev_nxt = pin_in[0];
        cb_tick = '0;
        cb_tick[0] = 1'b1;
        for (int k = 0; k < NUM_CB; k++)
        begin
            cb_nxt[k] = cb_r[k];
            cbcnt_nxt[k] = cbcnt_r[k];
        end
        for (int k = 1; k < NUM_CB; k++)
        begin
            if (!cb_r[k].from_pin || (pin_in[0] && !pin0_prev_r))
            begin
                if (cbcnt_r[k] >= cb_r[k].div)
                begin
                    cbcnt_nxt[k] = '0;
                    cb_tick[k] = 1'b1;
                end
                else
                begin
                    cbcnt_nxt[k] = cbcnt_r[k] + DIV_W'(1);
                end
            end
            if (bus_we && page == PAGE_CB && regsel == 4'(k))
            begin
                cb_nxt[k] = tiop_cb_type'(bus_wdata[CB_W-1:0]);
                cbcnt_nxt[k] = '0;
            end
        end
    end

    // =========================================================
    // ports: timing counter, transfers, strobes, register writes
    always_comb
    begin
        for (int i = 0; i < NUM_PORTS; i++)
        begin
            cfg_nxt[i] = cfg_r[i];
            st_nxt[i] = st_r[i];
            strobe_nxt[i] = 1'b0;
            xfer_evt[i] = 1'b0;
            port_tick[i] = (cfg_r[i].cb_sel < 3'(NUM_CB)) ? cb_tick[cfg_r[i].cb_sel] : 1'b0;
            if (cfg_r[i].enable && port_tick[i])
            begin
                st_nxt[i].cnt = st_r[i].cnt + CNT_W'(1);
                if (!cfg_r[i].timed || st_r[i].cnt == st_r[i].ptime)
                begin
                    if (cfg_r[i].dir_out)
                    begin
                        if (st_r[i].valid)
                        begin
                            st_nxt[i].pval = st_r[i].xfer & port_mask(i);
                            st_nxt[i].valid = 1'b0;
                            xfer_evt[i] = 1'b1;
                            strobe_nxt[i] = cfg_r[i].strobe_en;
                        end
                    end
                    else
                    begin
                        if (!st_r[i].valid
                            && (!cfg_r[i].strobe_en || strobe_in_qualifier[i])
                            && (cfg_r[i].cond_mode == COND_NONE
                                || (cfg_r[i].cond_mode == COND_EQ
                                    && (pin_in & port_mask(i)) == st_r[i].cond)
                                || (cfg_r[i].cond_mode == COND_NE
                                    && (pin_in & port_mask(i)) != st_r[i].cond)))
                        begin
                            st_nxt[i].xfer = pin_in & port_mask(i);
                            st_nxt[i].valid = 1'b1;
                            xfer_evt[i] = 1'b1;
                        end
                    end
                end
                if (xfer_evt[i])
                begin
                    st_nxt[i].tstamp = st_r[i].cnt;
                end
            end
            if (bus_we && page == 4'(i))
            begin
                case (regsel)
                    REG_CTRL: cfg_nxt[i] = tiop_cfg_type'(bus_wdata[CFG_W-1:0]);
                    REG_DATA:
                    begin
                        if (cfg_r[i].dir_out)
                        begin
                            st_nxt[i].xfer = bus_wdata & port_mask(i);
                            st_nxt[i].valid = 1'b1;
                        end
                    end
                    REG_TIME: st_nxt[i].ptime = bus_wdata[CNT_W-1:0];
                    REG_COND: st_nxt[i].cond = bus_wdata & port_mask(i);
                    default: ;
                endcase
            end
            // reading input data frees the register; a new sample wins
            if (bus_re && page == 4'(i) && regsel == REG_DATA && !cfg_r[i].dir_out
                && !xfer_evt[i])
            begin
                st_nxt[i].valid = 1'b0;
            end
        end
    end

    // =========================================================
    // read mux: data stand only in the cycle after the strobe
    always_comb
    begin
        rdata_nxt = '0;
        if (bus_re)
        begin
            if (page < 4'(NUM_PORTS))
            begin
                case (regsel)
                    REG_CTRL: rdata_nxt = 32'(cfg_r[page[2:0]]);
                    REG_DATA: rdata_nxt = st_r[page[2:0]].xfer;
                    REG_TIME: rdata_nxt = 32'(st_r[page[2:0]].ptime);
                    REG_COND: rdata_nxt = st_r[page[2:0]].cond;
                    REG_CNT: rdata_nxt = 32'(st_r[page[2:0]].cnt);
                    REG_TSTAMP: rdata_nxt = 32'(st_r[page[2:0]].tstamp);
                    REG_STAT: rdata_nxt = 32'(st_r[page[2:0]].valid);
                    default: rdata_nxt = '0;
                endcase
            end
            else if (page == PAGE_CB && regsel < 4'(NUM_CB))
            begin
                rdata_nxt = 32'(cb_r[regsel[2:0]]);
            end
        end
    end

    // =========================================================
    // pin multiplexer
    always_comb
    begin
        logic found;
        found = 1'b0;
        pin_out_nxt = '0;
        pin_oe_nxt = '0;
        for (int b = 0; b < PIN_W; b++)
        begin
            found = 1'b0;
            if (!(link_en && LINK_PIN_MASK[b]))
            begin
                // unshared pins fall to narrowest enabled port
                for (int i = 0; i < NUM_PORTS; i++)
                begin
                    if (!found && cfg_r[i].enable && b < port_width(i))
                    begin
                        found = 1'b1;
                        if (cfg_r[i].dir_out)
                        begin
                            if (cfg_r[i].open_col)
                            begin
                                pin_out_nxt[b] = 1'b0;
                                pin_oe_nxt[b] = !st_r[i].pval[b];
                            end
                            else
                            begin
                                pin_out_nxt[b] = st_r[i].pval[b];
                                pin_oe_nxt[b] = 1'b1;
                            end
                        end
                    end
                end
            end
        end
    end

    // =========================================================
    // registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                cfg_r[i] <= CFG_RST;
                st_r[i] <= STATE_RST;
            end
            for (int k = 0; k < NUM_CB; k++)
            begin
                cb_r[k] <= CB_RST;
                cbcnt_r[k] <= '0;
            end
            pin0_prev_r <= 1'b0;
            rdata_r <= '0;
            pin_out_r <= '0;
            pin_oe_r <= '0;
            pin_pd_r <= '1;
            strobe_r <= '0;
        end
        else if (ce)
        begin
            cfg_r <= cfg_nxt;
            st_r <= st_nxt;
            cb_r <= cb_nxt;
            cbcnt_r <= cbcnt_nxt;
            pin0_prev_r <= pin0_prev_nxt;
            rdata_r <= rdata_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            pin_pd_r <= '0;
            strobe_r <= strobe_nxt;
        end
    end

    // =========================================================
    // assertions
    a_cnt_read_now: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && bus_re && page == 4'h0 && regsel == REG_CNT)
        |=> (bus_rdata == 32'($past(st_r[0].cnt))))
        else $error("counter read does not show counter");

    a_read_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && !bus_re) |=> (bus_rdata == '0))
        else $error("read data outside read cycle");

    a_open_col_drive: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && cfg_r[1].enable && cfg_r[1].dir_out && cfg_r[1].open_col)
        |=> !(pin_oe[1] && pin_out[1]) && (pin_oe[1] == !$past(st_r[1].pval[1])))
        else $error("open collector pin driven high");

    a_input_undriven: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && cfg_r[2].enable && !cfg_r[2].dir_out) |=> !pin_oe[7])
        else $error("input port drives its pin");

    a_narrow_wins: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && cfg_r[2].enable && cfg_r[2].dir_out && !cfg_r[2].open_col
         && cfg_r[4].enable)
        |=> pin_oe[5] && (pin_out[5] == $past(st_r[2].pval[5])))
        else $error("narrow port lost shared pin");

    a_link_takes: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && link_en) |=> ((pin_oe & LINK_PIN_MASK) == '0))
        else $error("port drives link pin");

    a_reset_cb_zero: assert property (@(posedge clk)
        $past(sys_rst) |-> (cfg_r[2].cb_sel == 3'h0 && cfg_r[4].cb_sel == 3'h0))
        else $error("port not on clock block zero after reset");

    a_reset_pass: assert property (@(posedge clk)
        $past(sys_rst) |-> (cb_r[1].div == '0 && cb_r[5].div == '0))
        else $error("divider not pass-through after reset");

    a_reset_pulldown: assert property (@(posedge clk)
        sys_rst |=> (pin_pd == '1))
        else $error("pull-down missing in reset");

    a_stamp_capture: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && xfer_evt[1]) |=> (st_r[1].tstamp == $past(st_r[1].cnt)))
        else $error("timestamp not captured");

    a_cnt_step: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && cfg_r[0].enable && port_tick[0])
        |=> (st_r[0].cnt == $past(st_r[0].cnt) + CNT_W'(1)))
        else $error("port counter did not step");

endmodule : tiop_port_unit

// ===== tiop_ext_model.sv
// model of the external hardware wired to the port pins
`timescale 1ns/10ps

module tiop_ext_model (
    input wire logic clk,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pin_pd,
    input wire logic [31:0] drv_en,
    input wire logic [31:0] drv_val,
    input wire logic [4:0] strobe_req,
    output logic [31:0] pin_in,
    output logic [4:0] strobe_in_qualifier
);
    logic [31:0] noise_r = 32'h0000_0000;

    // =========================================================
    // pin levels
    // undriven pins without pull-down flip every cycle
    always @(posedge clk)
    begin
        noise_r <= ~noise_r;
        pin_in <= (pin_oe & pin_out) | (~pin_oe & drv_en & drv_val)
            | (~pin_oe & ~drv_en & ~pin_pd & noise_r);
    end

    // =========================================================
    // input strobes
    // external data ready
    always @(posedge clk)
    begin
        strobe_in_qualifier <= strobe_req;
    end
endmodule : tiop_ext_model

// ===== tiop_port_unit_test.sv
// self-checking testbench of the timed i/o port unit
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got %0h exp %0h", $time, g, e); end end

module tiop_port_unit_test;
    import tiop_pkg::*;
    logic clk;
    logic sys_rst;
    logic ce;
    logic bus_we;
    logic bus_re;
    logic link_en;
    logic [7:0] bus_addr;
    logic [31:0] bus_wdata, bus_rdata, pin_in, pin_out, pin_oe, pin_pd;
    logic [31:0] drv_en, drv_val, rd_v, t0, d;
    logic [4:0] strobe_in_qualifier, strobe_out_qualifier, strobe_req;
    logic [31:0] rng = 32'h47A1_73CF;
    logic [31:0] dout [5];
    int wid [5] = '{1, 4, 8, 16, 32};
    int en [5];
    int n_errors = 0;
    int checks = 0;
    int cnt_pulse = 0;

    // =========================================================
    // design and far side
    tiop_port_unit tiop_port_unit_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
        .bus_rdata(bus_rdata), .link_en(link_en), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pd(pin_pd), .strobe_in_qualifier(strobe_in_qualifier),
        .strobe_out_qualifier(strobe_out_qualifier));
    tiop_ext_model tiop_ext_model_inst (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pd(pin_pd), .drv_en(drv_en), .drv_val(drv_val), .strobe_req(strobe_req),
        .pin_in(pin_in), .strobe_in_qualifier(strobe_in_qualifier));

    // =========================================================
    // clock, strobe counter, watchdog
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
        if (strobe_out_qualifier[0] === 1'b1) cnt_pulse++;
    initial
    begin
        #2_000_000;
        n_errors++;
        results();
    end

    // =========================================================
    // helpers
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    function automatic logic [7:0] ra(input logic [3:0] pg, input logic [3:0] r);
        return {pg, r};
    endfunction : ra
    function automatic logic [31:0] mk(input int p);
        return (wid[p] == 32) ? 32'hFFFF_FFFF : ((32'h1 << wid[p]) - 32'h1);
    endfunction : mk
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        bus_addr <= a;
        bus_wdata <= v;
        bus_we <= 1'b1;
        @(posedge clk);
        bus_we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        bus_addr <= a;
        bus_re <= 1'b1;
        @(posedge clk);
        bus_re <= 1'b0;
        @(negedge clk);
        v = bus_rdata;
    endtask : rd
    task automatic clr();
        for (int p = 0; p < 5; p++)
        begin
            wr(ra(4'(p), REG_CTRL), 32'h0);
            en[p] = 0;
        end
    endtask : clr
    // bench model of the pin multiplexer, output ports only
    task automatic pin_check();
        logic [31:0] eo, ee;
        int own;
        eo = 32'h0;
        ee = 32'h0;
        for (int b = 0; b < 32; b++)
        begin
            own = -1;
            for (int p = 4; p >= 0; p--)
                if (en[p] != 0 && b < wid[p]) own = p;
            if (own >= 0 && !(link_en && LINK_PIN_MASK[b]))
            begin
                ee[b] = 1'b1;
                eo[b] = dout[own][b];
            end
        end
        @(negedge clk);
        `CHK(pin_oe, ee)
        `CHK(pin_out, eo)
    endtask : pin_check
    task automatic results();
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // =========================================================
    // main sequence
    initial
    begin
        {sys_rst, ce, bus_we, bus_re, link_en} = 5'b11000;
        {bus_addr, bus_wdata, drv_en, drv_val, strobe_req} = '0;
        wt(12);
        @(negedge clk);
        `CHK(pin_pd, 32'hFFFF_FFFF)
        @(posedge clk);
        sys_rst <= 1'b0;
        // reset values, clock block registers, unmapped reads
        for (int p = 0; p < 5; p++)
        begin
            rd(ra(4'(p), REG_CTRL), rd_v);
            `CHK(rd_v, 32'h0)
        end
        `CHK(pin_pd, 32'h0)
        for (int k = 0; k < 6; k++)
        begin
            rd(ra(PAGE_CB, 4'(k)), rd_v);
            `CHK(rd_v, 32'h0)
            wr(ra(PAGE_CB, 4'(k)), 32'h0000_01A5);
            rd(ra(PAGE_CB, 4'(k)), rd_v);
            `CHK(rd_v, (k == 0) ? 32'h0 : 32'h0000_01A5)
        end
        rd(8'h77, rd_v);
        `CHK(rd_v, 32'h0)
        @(negedge clk);
        `CHK(bus_rdata, 32'h0)
        // each width drives its own pins at full width
        for (int p = 0; p < 5; p++)
        begin
            clr();
            dout[p] = xs();
            en[p] = 1;
            wr(ra(4'(p), REG_CTRL), 32'h3);
            wr(ra(4'(p), REG_DATA), dout[p]);
            wt(3);
            pin_check();
            rd(ra(4'(p), REG_DATA), rd_v);
            `CHK(rd_v, dout[p] & mk(p))
        end
        // narrow port over wide port, then link takes its pins
        clr();
        dout[4] = xs();
        dout[2] = xs();
        en[4] = 1;
        en[2] = 1;
        wr(ra(4'h4, REG_CTRL), 32'h3);
        wr(ra(4'h4, REG_DATA), dout[4]);
        wr(ra(4'h2, REG_CTRL), 32'h3);
        wr(ra(4'h2, REG_DATA), dout[2]);
        wt(3);
        pin_check();
        wt(1);
        link_en <= 1'b1;
        wt(3);
        pin_check();
        wt(1);
        link_en <= 1'b0;
        // open collector
        clr();
        d = xs();
        wr(ra(4'h1, REG_CTRL), 32'h7);
        wr(ra(4'h1, REG_DATA), d);
        wt(3);
        @(negedge clk);
        `CHK(pin_oe[3:0], ~d[3:0])
        `CHK(pin_out[3:0] & pin_oe[3:0], 4'h0)
        // plain input; data writes to an input are dropped
        clr();
        d = xs();
        drv_en <= 32'hFF;
        drv_val <= d;
        wr(ra(4'h2, REG_CTRL), 32'h1);
        wt(4);
        @(negedge clk);
        `CHK(pin_oe, 32'h0)
        wr(ra(4'h2, REG_DATA), ~d);
        rd(ra(4'h2, REG_DATA), rd_v);
        `CHK(rd_v, d & 32'hFF)
        // conditional sampling, equal then not equal
        for (int m = 1; m < 3; m++)
        begin
            clr();
            drv_val <= (m == 1) ? 32'h11 : 32'h5A;
            wr(ra(4'h2, REG_COND), 32'h5A);
            wr(ra(4'h2, REG_CTRL), 32'h1 | 32'(m << 4));
            rd(ra(4'h2, REG_DATA), rd_v);
            wt(4);
            rd(ra(4'h2, REG_STAT), rd_v);
            `CHK(rd_v[0], 1'b0)
            wt(1);
            drv_val <= (m == 1) ? 32'h5A : 32'h11;
            wt(4);
            drv_val <= (m == 1) ? 32'h11 : 32'h5A;
            wt(3);
            rd(ra(4'h2, REG_DATA), rd_v);
            `CHK(rd_v, (m == 1) ? 32'h5A : 32'h11)
        end
        // input strobe holds the sample back
        clr();
        drv_val <= 32'h6;
        wr(ra(4'h1, REG_CTRL), 32'h9);
        rd(ra(4'h1, REG_DATA), rd_v);
        wt(4);
        rd(ra(4'h1, REG_STAT), rd_v);
        `CHK(rd_v[0], 1'b0)
        wt(1);
        strobe_req <= 5'h02;
        wt(4);
        strobe_req <= 5'h00;
        rd(ra(4'h1, REG_DATA), rd_v);
        `CHK(rd_v, 32'h6)
        // timed output, counter and timestamp
        clr();
        drv_en <= 32'h0;
        d = xs();
        wr(ra(4'h3, REG_CTRL), 32'h43);
        rd(ra(4'h3, REG_CNT), t0);
        rd(ra(4'h3, REG_CNT), rd_v);
        `CHK(rd_v[15:0], t0[15:0] + 16'd2)
        // clock enable low for five edges freezes the counter
        wt(1);
        ce <= 1'b0;
        wt(5);
        ce <= 1'b1;
        rd(ra(4'h3, REG_CNT), rd_v);
        `CHK(rd_v[15:0], t0[15:0] + 16'd5)
        wr(ra(4'h3, REG_TIME), t0 + 32'd40);
        wr(ra(4'h3, REG_DATA), d);
        @(negedge clk);
        `CHK(pin_out[15:0], dout[3][15:0])
        wt(50);
        @(negedge clk);
        `CHK(pin_out[15:0], d[15:0])
        rd(ra(4'h3, REG_TSTAMP), rd_v);
        `CHK(rd_v, {16'h0, t0[15:0] + 16'd40})
        // output strobe: one pulse per transfer
        clr();
        wr(ra(4'h0, REG_CTRL), 32'hB);
        @(negedge clk);
        cnt_pulse = 0;
        wr(ra(4'h0, REG_DATA), 32'h1);
        wt(10);
        `CHK(cnt_pulse, 1)
        // clock block fed from pin 0, undivided then halved
        clr();
        drv_en <= 32'h1;
        drv_val <= 32'h0;
        wr(ra(4'h3, REG_CTRL), 32'h81);
        for (int dv = 0; dv < 2; dv++)
        begin
            wr(ra(PAGE_CB, 4'h1), 32'h100 | 32'(dv));
            wt(3);
            rd(ra(4'h3, REG_CNT), t0);
            repeat (8)
            begin
                wt(1);
                drv_val <= 32'h1;
                wt(2);
                drv_val <= 32'h0;
                wt(1);
            end
            wt(6);
            rd(ra(4'h3, REG_CNT), rd_v);
            `CHK(rd_v[15:0], t0[15:0] + 16'(8 >> dv))
        end
        results();
    end
endmodule : tiop_port_unit_test
